/* rgc_defines.svh */
// register offsets, field positions, reset values and decode constants
`ifndef RGC_DEFINES_SVH
`define RGC_DEFINES_SVH
`define RGC_ADDR_TUNE 7'h67
`define RGC_ADDR_REF 7'h68
`define RGC_ADDR_GAIN1 7'h69
`define RGC_ADDR_GAIN2 7'h6A
`define RGC_ADDR_RATE 7'h6F
`define RGC_ADDR_CODE 7'h70
`define RGC_RST_TUNE 8'h1D
`define RGC_RST_REF 8'h00
`define RGC_RST_GAIN1 8'h20
`define RGC_RST_GAIN2 8'h00
`define RGC_RST_RATE 8'h3D
`define RGC_RST_CODE 8'h00
`define RGC_TUNE_OVR 4
`define RGC_REF_MASK 8'h1F
`define RGC_GAIN1_MASK 8'h3F
`define RGC_CODE_MASK 8'h1F
`define RGC_AGC_EN 5
`define RGC_LNA_BIT 4
`define RGC_BYPASS_BIT 7
`define RGC_SLOW_BIT 6
`define RGC_COMP_HI 5
`define RGC_COMP_LO 2
`define RGC_PGA_MAX 4'h5
`define RGC_PHPWDN_BIT 4
`define RGC_PPOL_BIT 3
`define RGC_MINV_BIT 2
`define RGC_MAN_BIT 1
`define RGC_WHITE_BIT 0
`define RGC_LNA_MIN_DB 5'h05
`define RGC_LNA_MAX_DB 5'h19
`define RGC_PGA_STEP_DB 5'h03
`define RGC_REF_MV_05 11'h1F4
`define RGC_REF_MV_06 11'h258
`define RGC_REF_MV_07 11'h2BC
`define RGC_REF_MV_12 11'h4B0
`define RGC_SPI_CMD_BITS 4'h8
`define RGC_SPI_FRAME_BITS 4'h8
`endif

/* rgc_pkg.sv */
// types for the receiver gain and coding register bank
package rgc_pkg;
    typedef enum logic [1:0] {SpiCmd, SpiData, SpiDone} rgc_spi_state_t;
endpackage : rgc_pkg

/* rgc_reg_cell.sv */
// one 8-bit register with reset value and writable-bit mask
`timescale 1ns/10ps
`default_nettype none
module rgc_reg_cell #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstSync_n,
    // write port
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    // stored value
    output logic [7:0] value
);
    logic [7:0] value_q;
    always_ff @(posedge clock or negedge rstSync_n)
    begin
        if (!rstSync_n)
            value_q <= RESET_VAL;
        else if (wrEn)
            value_q <= (value_q & ~WR_MASK) | (wrData & WR_MASK);
    end
    assign value = value_q;
endmodule : rgc_reg_cell
`default_nettype wire

/* rgc_regs.sv */
// serial-port register bank for adc tuning, gain override and line coding
`timescale 1ns/10ps
`default_nettype none
`include "rgc_defines.svh"
module rgc_regs
    import rgc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // serial register port, mode 0, msb first, command bit 7 = write
    input wire logic spiSel_n,
    input wire logic spiSck,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOe,
    // internal calibration and loop status
    input wire logic [3:0] intCalValue,
    input wire logic [4:0] agcLoopGain,
    input wire logic preambleDetect,
    input wire logic lowPowerMode,
    // adc controls
    output logic adcReset,
    output logic adcRefDacEn,
    output logic adcEn,
    output logic [3:0] adcCalValue,
    output logic adcVcmEn,
    output logic adcOpenLoop,
    output logic [10:0] adcRefMv,
    // gain controls
    output logic agcEnable,
    output logic [4:0] lnaGainDb,
    output logic [4:0] pgaGainDb,
    output logic agcPreambleGate,
    output logic agcSlowRise,
    output logic [3:0] lnaComp,
    output logic [1:0] pgaThresh,
    // data rate and coding
    output logic [7:0] dataRateLow,
    output logic phPowerDown,
    output logic manchEn,
    output logic manchInvert,
    output logic preambleOnes,
    output logic whiteEn
);
    logic rstMeta_q;
    logic rstSync_n;
    logic sckMeta_q, sckSync_q, sckPrev_q;
    logic selMeta_q, selSync_q;
    logic mosiMeta_q, mosiSync_q;
    rgc_spi_state_t spiState_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [6:0] addr_q;
    logic isWrite_q;
    logic [7:0] rdShift_q;
    logic wrStrobe_q;
    logic [7:0] wrData_q;
    logic [5:0] wrSel;
    logic [7:0] regVal [6];
    logic [7:0] rdData;
    logic sckRise, sckFall;
    logic rdLoad_q;

    // reset released through two flops
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_q <= 1'b0;
            rstSync_n <= 1'b0;
        end
        else
        begin
            rstMeta_q <= 1'b1;
            rstSync_n <= rstMeta_q;
        end
    end

    // serial pins are slow next to clock; sampled and edge-detected
    always_ff @(posedge clock or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            sckMeta_q <= 1'b0;
            sckSync_q <= 1'b0;
            sckPrev_q <= 1'b0;
            selMeta_q <= 1'b1;
            selSync_q <= 1'b1;
            mosiMeta_q <= 1'b0;
            mosiSync_q <= 1'b0;
        end
        else
        begin
            sckMeta_q <= spiSck;
            sckSync_q <= sckMeta_q;
            sckPrev_q <= sckSync_q;
            selMeta_q <= spiSel_n;
            selSync_q <= selMeta_q;
            mosiMeta_q <= spiMosi;
            mosiSync_q <= mosiMeta_q;
        end
    end
    assign sckRise = sckSync_q & ~sckPrev_q;
    assign sckFall = ~sckSync_q & sckPrev_q;

    // frame: command byte then one data byte
    always_ff @(posedge clock or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            spiState_q <= SpiCmd;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            addr_q <= 7'h00;
            isWrite_q <= 1'b0;
            wrStrobe_q <= 1'b0;
            wrData_q <= 8'h00;
        end
        else
        begin
            wrStrobe_q <= 1'b0;
            if (selSync_q)
            begin
                spiState_q <= SpiCmd;
                bitCnt_q <= 4'h0;
            end
            else if (sckRise)
            begin
                shift_q <= {shift_q[6:0], mosiSync_q};
                bitCnt_q <= bitCnt_q + 4'h1;
                unique case (spiState_q)
                    SpiCmd:
                    begin
                        if (bitCnt_q == `RGC_SPI_CMD_BITS - 4'h1)
                        begin
                            isWrite_q <= shift_q[6];
                            addr_q <= {shift_q[5:0], mosiSync_q};
                            bitCnt_q <= 4'h0;
                            spiState_q <= SpiData;
                        end
                    end
                    SpiData:
                    begin
                        if (bitCnt_q == `RGC_SPI_FRAME_BITS - 4'h1)
                        begin
                            wrStrobe_q <= isWrite_q;
                            wrData_q <= {shift_q[6:0], mosiSync_q};
                            spiState_q <= SpiDone;
                        end
                    end
                    SpiDone:
                        bitCnt_q <= bitCnt_q;
                    default:
                        spiState_q <= SpiCmd;
                endcase
            end
        end
    end

    // read data is captured one clock after the command byte ends, once
    // the address register holds the new address, not the previous one
    always_ff @(posedge clock or negedge rstSync_n)
    begin
        if (!rstSync_n)
            rdLoad_q <= 1'b0;
        else
            rdLoad_q <= (spiState_q == SpiCmd);
    end

    // read data shifts out on falling edges during the data byte
    always_ff @(posedge clock or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            rdShift_q <= 8'h00;
            spiMiso <= 1'b0;
            spiMisoOe <= 1'b0;
        end
        else
        begin
            spiMisoOe <= ~selSync_q & (spiState_q == SpiData) & ~isWrite_q;
            if (rdLoad_q)
                rdShift_q <= rdData;
            else if (sckFall && spiState_q == SpiData)
            begin
                spiMiso <= rdShift_q[7];
                rdShift_q <= {rdShift_q[6:0], 1'b0};
            end
        end
    end

    // write decode; reserved and read-only bits masked in each cell
    assign wrSel[0] = wrStrobe_q & (addr_q == `RGC_ADDR_TUNE);
    assign wrSel[1] = wrStrobe_q & (addr_q == `RGC_ADDR_REF);
    assign wrSel[2] = wrStrobe_q & (addr_q == `RGC_ADDR_GAIN1);
    assign wrSel[3] = wrStrobe_q & (addr_q == `RGC_ADDR_GAIN2);
    assign wrSel[4] = wrStrobe_q & (addr_q == `RGC_ADDR_RATE);
    assign wrSel[5] = wrStrobe_q & (addr_q == `RGC_ADDR_CODE);

    rgc_reg_cell #(.RESET_VAL(`RGC_RST_TUNE), .WR_MASK(8'hFF)) uTune (
        .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrSel[0]),
        .wrData(wrData_q), .value(regVal[0]));
    rgc_reg_cell #(.RESET_VAL(`RGC_RST_REF), .WR_MASK(`RGC_REF_MASK)) uRef (
        .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrSel[1]),
        .wrData(wrData_q), .value(regVal[1]));
    rgc_reg_cell #(.RESET_VAL(`RGC_RST_GAIN1), .WR_MASK(`RGC_GAIN1_MASK))
        uGain1 (
        .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrSel[2]),
        .wrData(wrData_q), .value(regVal[2]));
    rgc_reg_cell #(.RESET_VAL(`RGC_RST_GAIN2), .WR_MASK(8'hFF)) uGain2 (
        .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrSel[3]),
        .wrData(wrData_q), .value(regVal[3]));
    rgc_reg_cell #(.RESET_VAL(`RGC_RST_RATE), .WR_MASK(8'hFF)) uRate (
        .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrSel[4]),
        .wrData(wrData_q), .value(regVal[4]));
    rgc_reg_cell #(.RESET_VAL(`RGC_RST_CODE), .WR_MASK(`RGC_CODE_MASK)) uCode (
        .clock(clock), .rstSync_n(rstSync_n), .wrEn(wrSel[5]),
        .wrData(wrData_q), .value(regVal[5]));

    // read mux; gain field shows the loop result while agc runs
    always_comb
    begin
        rdData = 8'h00;
        unique case (addr_q)
            `RGC_ADDR_TUNE: rdData = regVal[0];
            `RGC_ADDR_REF: rdData = regVal[1] & `RGC_REF_MASK;
            `RGC_ADDR_GAIN1:
                rdData = regVal[2][`RGC_AGC_EN] ?
                    {3'h1, agcLoopGain} : regVal[2];
            `RGC_ADDR_GAIN2: rdData = regVal[3];
            `RGC_ADDR_RATE: rdData = regVal[4];
            `RGC_ADDR_CODE: rdData = regVal[5] & `RGC_CODE_MASK;
            default: rdData = 8'h00;
        endcase
    end

    // adc controls
    always_ff @(posedge clock or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            adcReset <= 1'b0;
            adcRefDacEn <= 1'b0;
            adcEn <= 1'b0;
            adcCalValue <= 4'h0;
            adcVcmEn <= 1'b0;
            adcOpenLoop <= 1'b0;
            adcRefMv <= `RGC_REF_MV_05;
        end
        else
        begin
            adcReset <= regVal[0][7];
            adcRefDacEn <= regVal[0][6];
            adcEn <= regVal[0][5];
            adcCalValue <= regVal[0][`RGC_TUNE_OVR] ?
                regVal[0][3:0] : intCalValue;
            adcVcmEn <= regVal[1][4];
            adcOpenLoop <= regVal[1][3];
            // codes 010 to 110 are undefined; held at 0.7 V
            unique case (regVal[1][2:0])
                3'h0: adcRefMv <= `RGC_REF_MV_05;
                3'h1: adcRefMv <= `RGC_REF_MV_06;
                3'h7: adcRefMv <= `RGC_REF_MV_12;
                default: adcRefMv <= `RGC_REF_MV_07;
            endcase
        end
    end

    // gain controls; manual values drive whether agc is on or off
    always_ff @(posedge clock or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            agcEnable <= 1'b1;
            lnaGainDb <= `RGC_LNA_MIN_DB;
            pgaGainDb <= 5'h00;
            agcPreambleGate <= 1'b0;
            agcSlowRise <= 1'b0;
            lnaComp <= 4'h0;
            pgaThresh <= 2'h0;
        end
        else
        begin
            agcEnable <= regVal[2][`RGC_AGC_EN];
            lnaGainDb <= regVal[2][`RGC_LNA_BIT] ?
                `RGC_LNA_MAX_DB : `RGC_LNA_MIN_DB;
            if (regVal[2][3:0] > `RGC_PGA_MAX)
                pgaGainDb <= 5'(`RGC_PGA_MAX * `RGC_PGA_STEP_DB);
            else
                pgaGainDb <= 5'(regVal[2][3:0] * `RGC_PGA_STEP_DB);
            agcPreambleGate <= preambleDetect |
                regVal[3][`RGC_BYPASS_BIT];
            agcSlowRise <= regVal[3][`RGC_SLOW_BIT];
            lnaComp <= regVal[3][`RGC_COMP_HI:`RGC_COMP_LO];
            pgaThresh <= regVal[3][1:0];
        end
    end

    // data rate and line coding
    always_ff @(posedge clock or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            dataRateLow <= `RGC_RST_RATE;
            phPowerDown <= 1'b0;
            manchEn <= 1'b0;
            manchInvert <= 1'b0;
            preambleOnes <= 1'b0;
            whiteEn <= 1'b0;
        end
        else
        begin
            dataRateLow <= regVal[4];
            phPowerDown <= regVal[5][`RGC_PHPWDN_BIT] & lowPowerMode;
            manchEn <= regVal[5][`RGC_MAN_BIT];
            manchInvert <= regVal[5][`RGC_MINV_BIT] &
                regVal[5][`RGC_MAN_BIT];
            preambleOnes <= regVal[5][`RGC_PPOL_BIT] &
                regVal[5][`RGC_MAN_BIT];
            whiteEn <= regVal[5][`RGC_WHITE_BIT];
        end
    end
endmodule : rgc_regs
`default_nettype wire

/* rgc_host_model.sv */
// host microcontroller model driving the serial register port
`timescale 1ns/10ps
`default_nettype none
module rgc_host_model (
    // clock
    input wire logic clock,
    // serial port
    output logic spiSel_n,
    output logic spiSck,
    output logic spiMosi,
    input wire logic spiMiso
);
    initial
    begin
        spiSel_n = 1'b1;
        spiSck = 1'b0;
        spiMosi = 1'b0;
    end
    // six clocks per phase: the port needs at least four after sync
    task automatic half();
        repeat (6) @(negedge clock);
    endtask : half
    // one frame, command then data, msb first, mode 0
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
        output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        rd = 8'h00;
        spiSel_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            spiMosi = sh[i];
            half();
            if (i < 8)
                rd = {rd[6:0], spiMiso};
            spiSck = 1'b1;
            half();
            spiSck = 1'b0;
        end
        half();
        spiSel_n = 1'b1;
        spiMosi = ~spiMosi;
        half();
    endtask : xfer
endmodule : rgc_host_model
`default_nettype wire

/* rgc_regs_assertions.sv */
// concurrent checks on the register bank ports
`timescale 1ns/10ps
`default_nettype none
module rgc_regs_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // watched ports
    input wire logic spiSel_n,
    input wire logic spiMisoOe,
    input wire logic preambleDetect,
    input wire logic lowPowerMode,
    input wire logic [10:0] adcRefMv,
    input wire logic [4:0] lnaGainDb,
    input wire logic [4:0] pgaGainDb,
    input wire logic agcPreambleGate,
    input wire logic phPowerDown,
    input wire logic manchEn,
    input wire logic manchInvert,
    input wire logic preambleOnes
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_ref_decode: assert property (
        adcRefMv inside {11'h1F4, 11'h258, 11'h2BC, 11'h4B0})
        else $error("reference outside decode table");
    a_lna_levels: assert property (
        lnaGainDb inside {5'h05, 5'h19}) else $error("lna gain illegal");
    a_pga_steps: assert property (
        pgaGainDb inside {5'h00, 5'h03, 5'h06, 5'h09, 5'h0C, 5'h0F})
        else $error("pga gain not a 3 dB step");
    a_preamble_gate: assert property (
        preambleDetect |=> agcPreambleGate) else $error("gate missed");
    a_phpd_lowpower: assert property (
        phPowerDown |-> $past(lowPowerMode)) else $error("phpd early");
    a_ppol_manch: assert property (
        preambleOnes |-> manchEn) else $error("polarity without coding");
    a_inv_manch: assert property (
        manchInvert |-> manchEn) else $error("invert without coding");
    a_miso_idle: assert property (
        spiSel_n [*6] |=> !spiMisoOe) else $error("miso driven idle");
endmodule : rgc_regs_chk
bind rgc_regs rgc_regs_chk u_chk (.*);
`default_nettype wire

/* test_rgc_regs.sv */
// self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
module test_rgc_regs;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic spiSel_n, spiSck, spiMosi, spiMiso, spiMisoOe, misoLine;
    logic [3:0] intCalValue = 4'h9;
    logic [4:0] agcLoopGain = 5'h0A;
    logic preambleDetect = 1'b0;
    logic lowPowerMode = 1'b0;
    logic adcReset, adcRefDacEn, adcEn, adcVcmEn, adcOpenLoop, agcEnable;
    logic agcPreambleGate, agcSlowRise, phPowerDown, manchEn, manchInvert;
    logic preambleOnes, whiteEn;
    logic [3:0] adcCalValue, lnaComp;
    logic [10:0] adcRefMv;
    logic [4:0] lnaGainDb, pgaGainDb;
    logic [1:0] pgaThresh;
    logic [7:0] dataRateLow, rdv;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    // released miso toggles so a stale bit can never pass
    assign misoLine = spiMisoOe ? spiMiso : clock;
    rgc_regs dut (.*);
    rgc_host_model host (.clock(clock), .spiSel_n(spiSel_n),
        .spiSck(spiSck), .spiMosi(spiMosi), .spiMiso(misoLine));
    always #20 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    task automatic cmp(input string nm, input logic [10:0] ex,
        input logic [10:0] got);
        n_compared++;
        if (got !== ex)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({1'b1, a}, d, rdv);
        repeat (2) @(negedge clock);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] ex);
        host.xfer({1'b0, a}, 8'h00, rdv);
        cmp("readback", {3'b000, ex}, {3'b000, rdv});
    endtask : rd
    task automatic t_reset();
        cmp("calValue", 4'hD, adcCalValue);
        cmp("agcEnable", 1'b1, agcEnable);
        cmp("lnaGain", 5'h05, lnaGainDb);
        cmp("rateLow", 8'h3D, dataRateLow);
        rd(7'h67, 8'h1D);
        rd(7'h69, 8'h2A);
        rd(7'h6F, 8'h3D);
        rd(7'h01, 8'h00);
    endtask : t_reset
    task automatic t_cal();
        wr(7'h67, 8'hE5);
        cmp("calValue", 4'h9, adcCalValue);
        cmp("adcReset", 1'b1, adcReset);
        cmp("refDacEn", 1'b1, adcRefDacEn);
        cmp("adcEn", 1'b1, adcEn);
        wr(7'h67, 8'h1A);
        cmp("calValue", 4'hA, adcCalValue);
    endtask : t_cal
    task automatic t_ref();
        logic [10:0] mv [4] = '{11'h1F4, 11'h258, 11'h2BC, 11'h4B0};
        logic [2:0] code [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
        for (int i = 0; i < 4; i++)
        begin
            wr(7'h68, {5'h1F, code[i]});
            cmp("refMv", mv[i], adcRefMv);
            cmp("vcmEn", 1'b1, adcVcmEn);
            cmp("openLoop", 1'b1, adcOpenLoop);
            rd(7'h68, {5'h03, code[i]});
        end
    endtask : t_ref
    task automatic t_gain();
        wr(7'h69, 8'hDD);
        cmp("agcEnable", 1'b0, agcEnable);
        cmp("lnaGain", 5'h19, lnaGainDb);
        rd(7'h69, 8'h1D);
        for (int c = 0; c < 8; c++)
        begin
            wr(7'h69, 8'(c));
            cmp("pgaGain", (c > 5) ? 11'h00F : 11'(3 * c), pgaGainDb);
            cmp("lnaGain", 5'h05, lnaGainDb);
        end
    endtask : t_gain
    task automatic t_aux();
        wr(7'h6A, 8'hA6);
        cmp("gate", 1'b1, agcPreambleGate);
        cmp("comp", 4'h9, lnaComp);
        cmp("thresh", 2'h2, pgaThresh);
        cmp("slow", 1'b0, agcSlowRise);
        wr(7'h6A, 8'h40);
        cmp("slow", 1'b1, agcSlowRise);
        cmp("gate", 1'b0, agcPreambleGate);
        preambleDetect = 1'b1;
        repeat (2) @(negedge clock);
        cmp("gate", 1'b1, agcPreambleGate);
        preambleDetect = 1'b0;
        rd(7'h6A, 8'h40);
    endtask : t_aux
    task automatic t_code();
        wr(7'h70, 8'hFD);
        cmp("manchEn", 1'b0, manchEn);
        cmp("manchInv", 1'b0, manchInvert);
        cmp("ppol", 1'b0, preambleOnes);
        cmp("white", 1'b1, whiteEn);
        cmp("phPd", 1'b0, phPowerDown);
        lowPowerMode = 1'b1;
        repeat (2) @(negedge clock);
        cmp("phPd", 1'b1, phPowerDown);
        rd(7'h70, 8'h1D);
        wr(7'h70, 8'h0E);
        cmp("manchEn", 1'b1, manchEn);
        cmp("manchInv", 1'b1, manchInvert);
        cmp("ppol", 1'b1, preambleOnes);
        cmp("white", 1'b0, whiteEn);
        cmp("phPd", 1'b0, phPowerDown);
    endtask : t_code
    task automatic t_rate();
        wr(7'h6F, 8'hA5);
        cmp("rateLow", 8'hA5, dataRateLow);
        wr(7'h01, 8'hFF);
        rd(7'h6F, 8'hA5);
        rd(7'h01, 8'h00);
    endtask : t_rate
    initial
    begin
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
        t_reset();
        t_cal();
        t_ref();
        t_gain();
        t_aux();
        t_code();
        t_rate();
        end_sim();
    end
endmodule : test_rgc_regs
`default_nettype wire
